// ### posc_strap_capture.sv
`timescale 1ns/10ps
// Summary of operation
// - Every strap pixel pin is weakly pulled high so an unstrapped pin reads one during reset.
// - When reset is released the strap levels are sampled into the four strap configuration registers.
// - While reset is asserted the state machine returns to its initial state and all registers but the strap synchroniser stages take defaults.
// - Once the straps are captured the pull resistors leave the pixel pins working as a normal data bus.
// - Strap bits 1-0 pick the host bus, 10b for PCI and 01b for VL-Bus, and the board must strap one.
// - Strap bit 4 enables video ROM access on VL-Bus when one and disables it when zero.
// - Strap bits 7-5 give memory size: 000 is 4 MB, 100 is 2 MB, 110 is 1 MB, others reserved.
// - Software may overwrite the captured memory size field after reset.
// - On VL-Bus strap bit 8 enables the chip, a zero leaving only video ROM accesses served.
// - The clock select strap picks external clocks when zero and internal synthesized clocks when one.
// - With the snoop strap zero the device does not answer host writes to the palette RAMDAC.
// - With the snoop strap one the device answers host writes to the palette RAMDAC, but only on VL-Bus.
// - Dot clock rates above 80 MHz use clock doubling in the pixel path.
module posc_strap_capture (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [posc_pkg::STRAP_W-1:0] strap_pixel_pins_in,
   input wire logic [posc_pkg::STRAP_W-1:0] pix_data_out,
   input wire logic [posc_pkg::STRAP_W-1:0] pix_data_drive,
   output logic [posc_pkg::STRAP_W-1:0] strap_pixel_pins_out,
   output logic [posc_pkg::STRAP_W-1:0] strap_pixel_pins_oe_n,
   output logic [posc_pkg::STRAP_W-1:0] strap_pixel_pins_pull_up,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic bus_pci_en,
   output logic bus_vl_en,
   output logic chip_enable,
   output logic rom_enable,
   output logic clk_internal,
   output logic ramdac_snoop_en,
   output logic dot_double_en,
   output logic [1:0] page_mode,
   output logic [2:0] mem_size
);
   typedef struct packed {
      posc_pkg::posc_state_t state;
      logic [7:0] cfg_a;
      logic [7:0] cfg_b;
      logic [7:0] cfg_c;
      logic [7:0] cfg_d;
      logic [7:0] dot_mhz;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic [posc_pkg::STRAP_W-1:0] pin_o;
      logic [posc_pkg::STRAP_W-1:0] pin_oe_n;
      logic pull_up;
      logic [10:0] outs;
      logic [1:0] page;
      logic [2:0] mem;
   } posc_top_t;

   posc_top_t st_q, st_d;
   logic [posc_pkg::STRAP_W-1:0] strap_val;
   logic strap_stable;
   logic wr_acc;
   logic rd_acc;
   posc_cfg_if cfg_bus ();

   posc_strap_sync u_sync (
      .pclk(pclk),
      .pins(strap_pixel_pins_in),
      .value(strap_val),
      .stable(strap_stable)
   );

   assign cfg_bus.cfg_a = st_q.cfg_a;
   assign cfg_bus.cfg_b = st_q.cfg_b;
   assign cfg_bus.cfg_c = st_q.cfg_c;
   assign cfg_bus.cfg_d = st_q.cfg_d;
   assign cfg_bus.dot_mhz = st_q.dot_mhz;

   posc_decode u_dec (
      .cfg(cfg_bus)
   );

   function automatic logic [31:0] rd_mux(input logic [7:0] a, input posc_top_t s, input logic [7:0] stat);
      unique case (a)
         posc_pkg::ADDR_CFG_A: rd_mux = {24'h000000, s.cfg_a};
         posc_pkg::ADDR_CFG_B: rd_mux = {24'h000000, s.cfg_b};
         posc_pkg::ADDR_CFG_C: rd_mux = {24'h000000, s.cfg_c};
         posc_pkg::ADDR_CFG_D: rd_mux = {24'h000000, s.cfg_d};
         posc_pkg::ADDR_STATUS: rd_mux = {24'h000000, stat};
         posc_pkg::ADDR_DOT_CTRL: rd_mux = {24'h000000, s.dot_mhz};
         default: rd_mux = 32'h00000000;
      endcase
   endfunction : rd_mux

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == posc_pkg::ADDR_CFG_A) || (a == posc_pkg::ADDR_CFG_B) || (a == posc_pkg::ADDR_CFG_C)
         || (a == posc_pkg::ADDR_CFG_D) || (a == posc_pkg::ADDR_STATUS) || (a == posc_pkg::ADDR_DOT_CTRL);
   endfunction : addr_ok

   assign wr_acc = psel && penable && pwrite && st_q.ready;
   assign rd_acc = psel && penable && !pwrite && st_q.ready;

   always_comb begin
      logic [7:0] stat;
      stat = {2'h0, (st_q.state == posc_pkg::POSC_RUN), cfg_bus.dot_double, cfg_bus.chip_en,
         cfg_bus.mem_bad, cfg_bus.page_bad, cfg_bus.bus_bad};
      st_d = st_q;
      // Slave answers one cycle after the setup, so no access has a wait state
      st_d.ready = psel && !(penable && st_q.ready);
      st_d.slverr = psel && !addr_ok(paddr) && !(penable && st_q.ready);
      if (psel && !penable) begin
         st_d.rdata = rd_mux(paddr, st_q, stat);
      end
      unique case (st_q.state)
         posc_pkg::POSC_IN_RESET: begin
            // First edge after release: move to capture, which waits for the pin synchroniser to settle
            st_d.state = posc_pkg::POSC_CAPTURE;
         end
         posc_pkg::POSC_CAPTURE: begin
            // Straps are captured once, from the settled synchroniser
            if (strap_stable) begin
               st_d.cfg_a = strap_val[7:0];
               st_d.cfg_b = strap_val[15:8];
               st_d.cfg_c = strap_val[23:16];
               st_d.cfg_d = {3'h0, strap_val[28:24]};
               st_d.state = posc_pkg::POSC_RUN;
            end
         end
         posc_pkg::POSC_RUN: begin
            // Pins no longer reach the registers; only software writes change them
            if (wr_acc && paddr == posc_pkg::ADDR_CFG_A) begin
               st_d.cfg_a[posc_pkg::MEM_LSB +: 3] = pwdata[posc_pkg::MEM_LSB +: 3];
            end
            if (wr_acc && paddr == posc_pkg::ADDR_DOT_CTRL) begin
               st_d.dot_mhz = pwdata[7:0];
            end
         end
      endcase
      // Pull-up only matters until the capture; the pins then behave as pixel data
      st_d.pull_up = (st_q.state != posc_pkg::POSC_RUN);
      st_d.pin_o = pix_data_out;
      st_d.pin_oe_n = (st_q.state == posc_pkg::POSC_RUN) ? ~pix_data_drive : '1;
      st_d.outs = {cfg_bus.bus_pci, cfg_bus.bus_vl, cfg_bus.chip_en, cfg_bus.rom_en, cfg_bus.clk_int,
         cfg_bus.snoop_en, cfg_bus.dot_double, 4'h0};
      st_d.page = st_q.cfg_a[posc_pkg::PAGE_LSB +: 2];
      st_d.mem = st_q.cfg_a[posc_pkg::MEM_LSB +: 3];
   end

   // All state returns to defaults while reset is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q.state <= posc_pkg::POSC_IN_RESET;
         st_q.cfg_a <= posc_pkg::CFG_RESET;
         st_q.cfg_b <= posc_pkg::CFG_RESET;
         st_q.cfg_c <= posc_pkg::CFG_RESET;
         st_q.cfg_d <= posc_pkg::CFG_RESET;
         st_q.dot_mhz <= 8'h00;
         st_q.rdata <= 32'h00000000;
         st_q.ready <= 1'b0;
         st_q.slverr <= 1'b0;
         st_q.pin_o <= '0;
         st_q.pin_oe_n <= '1;
         st_q.pull_up <= 1'b1;
         st_q.outs <= 11'h000;
         st_q.page <= 2'h0;
         st_q.mem <= 3'h0;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.slverr;
   assign strap_pixel_pins_out = st_q.pin_o;
   assign strap_pixel_pins_oe_n = st_q.pin_oe_n;
   assign strap_pixel_pins_pull_up = {posc_pkg::STRAP_W{st_q.pull_up}};
   assign bus_pci_en = st_q.outs[10];
   assign bus_vl_en = st_q.outs[9];
   assign chip_enable = st_q.outs[8];
   assign rom_enable = st_q.outs[7];
   assign clk_internal = st_q.outs[6];
   assign ramdac_snoop_en = st_q.outs[5];
   assign dot_double_en = st_q.outs[4];
   assign page_mode = st_q.page;
   assign mem_size = st_q.mem;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_capture;
      (st_q.state == posc_pkg::POSC_CAPTURE) && strap_stable;
   endsequence
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   sequence s_live;
      st_q.state != posc_pkg::POSC_IN_RESET;
   endsequence
   sequence s_run;
      st_q.state == posc_pkg::POSC_RUN;
   endsequence

   cap_loads_a: assert property (s_capture |=> st_q.cfg_a == $past(strap_val[7:0]))
      else $error("strap capture missed cfg a");
   cap_state_a: assert property (s_capture |=> st_q.state == posc_pkg::POSC_RUN)
      else $error("capture did not enter run");
   hold_cfg_b_a: assert property (st_q.state == posc_pkg::POSC_RUN |=> $stable(st_q.cfg_b))
      else $error("cfg b changed after capture");
   mem_write_a: assert property (st_q.state == posc_pkg::POSC_RUN && wr_acc && paddr == posc_pkg::ADDR_CFG_A
      |=> st_q.cfg_a[7:5] == $past(pwdata[7:5]))
      else $error("memory size write lost");
   pull_off_a: assert property (st_q.state == posc_pkg::POSC_RUN |=> !st_q.pull_up)
      else $error("pull up stays after capture");
   pin_normal_a: assert property (st_q.state == posc_pkg::POSC_RUN
      |=> st_q.pin_oe_n == ~$past(pix_data_drive))
      else $error("pixel pins not driven normally");
   snoop_gate_a: assert property (##1 ramdac_snoop_en |-> $past(st_q.cfg_b[4]) && $past(cfg_bus.bus_vl))
      else $error("snoop on without strap");
   // Outputs still hold their reset value one edge after release, so that edge is skipped
   chip_en_a: assert property (##1 (!chip_enable && $past(st_q.state) != posc_pkg::POSC_IN_RESET)
      |-> $past(cfg_bus.bus_vl) && !$past(st_q.cfg_b[0]))
      else $error("chip disabled wrongly");
   double_a: assert property (st_q.dot_mhz > 8'd80 |=> dot_double_en)
      else $error("no doubling above threshold");
   apb_wait_a: assert property (psel && !penable |=> pready)
      else $error("apb answer late");

   // Reset release and capture
   rel_state_a: assert property (presetn && st_q.state == posc_pkg::POSC_IN_RESET
      |=> st_q.state == posc_pkg::POSC_CAPTURE)
      else $error("state machine stuck after reset");
   cap_loads_b_a: assert property (s_capture
      |=> st_q.cfg_b == $past(strap_val[15:8]) && st_q.cfg_d == {3'h0, $past(strap_val[28:24])})
      else $error("strap capture missed cfg b or d");
   cap_loads_c_a: assert property (s_capture
      |=> st_q.cfg_c == $past(strap_val[23:16]))
      else $error("strap capture missed cfg c");
   pull_hold_a: assert property (st_q.state != posc_pkg::POSC_RUN
      |=> st_q.pull_up && (&st_q.pin_oe_n))
      else $error("pins released before capture");
   pin_out_a: assert property (s_live
      |=> strap_pixel_pins_out == $past(pix_data_out))
      else $error("pixel data not passed through");

   // Captured values hold in run; only the memory size and dot clock take writes
   ro_hold_a: assert property (s_run
      |=> $stable(st_q.cfg_c) && $stable(st_q.cfg_d) && $stable(st_q.cfg_a[4:0]))
      else $error("read-only strap field changed");
   mem_keep_a: assert property (s_run ##0 !(wr_acc && paddr == posc_pkg::ADDR_CFG_A)
      |=> $stable(st_q.cfg_a[7:5]))
      else $error("memory size changed without a write");
   wr_ro_a: assert property (s_run ##0 (wr_acc && paddr == posc_pkg::ADDR_CFG_B)
      |=> $stable(st_q.cfg_b))
      else $error("cfg b took a write");
   dot_write_a: assert property (s_run ##0 (wr_acc && paddr == posc_pkg::ADDR_DOT_CTRL)
      |=> st_q.dot_mhz == $past(pwdata[7:0]))
      else $error("dot clock write lost");

   // Decoded outputs follow the registers one edge later
   bus_sel_a: assert property (s_live
      |=> bus_pci_en == ($past(st_q.cfg_a[1:0]) == posc_pkg::BUS_PCI)
      && bus_vl_en == ($past(st_q.cfg_a[1:0]) == posc_pkg::BUS_VL))
      else $error("host bus select wrong");
   page_out_a: assert property (s_live
      |=> page_mode == $past(st_q.cfg_a[posc_pkg::PAGE_LSB +: 2]))
      else $error("page mode output wrong");
   mem_out_a: assert property (s_live
      |=> mem_size == $past(st_q.cfg_a[posc_pkg::MEM_LSB +: 3]))
      else $error("memory size output wrong");
   rom_gate_a: assert property (s_live
      |=> rom_enable == ($past(st_q.cfg_a[1:0]) != posc_pkg::BUS_VL || $past(st_q.cfg_a[posc_pkg::ROM_EN_BIT])))
      else $error("rom enable wrong");
   clk_sel_a: assert property (s_live
      |=> clk_internal == $past(st_q.cfg_b[posc_pkg::B_CLK_SEL_BIT]))
      else $error("clock select wrong");
   snoop_on_a: assert property (s_live ##0 (st_q.cfg_a[1:0] == posc_pkg::BUS_VL)
      ##0 st_q.cfg_b[posc_pkg::B_SNOOP_BIT] |=> ramdac_snoop_en)
      else $error("snoop off with strap set");
   chip_on_a: assert property (s_live ##0 (st_q.cfg_a[1:0] != posc_pkg::BUS_VL || st_q.cfg_b[0])
      |=> chip_enable)
      else $error("chip disabled with enable strap");
   dbl_off_a: assert property (s_live ##0 (st_q.dot_mhz <= 8'h50)
      |=> !dot_double_en)
      else $error("doubling at or below threshold");

   // Bus handshake
   apb_drop_a: assert property (s_setup ##1 s_access |=> !pready)
      else $error("apb answer held too long");
   rd_stand_a: assert property (s_setup ##0 (paddr == posc_pkg::ADDR_CFG_B)
      ##0 (st_q.state == posc_pkg::POSC_RUN) ##1 rd_acc
      |-> prdata == {24'h000000, st_q.cfg_b})
      else $error("read data not standing");
   bad_addr_a: assert property (s_setup ##0 !addr_ok(paddr)
      |=> pslverr && prdata == 32'h00000000)
      else $error("unmapped address not refused");
endmodule : posc_strap_capture

// ### posc_pkg.sv
package posc_pkg;
   // Register byte addresses on APB
   localparam logic [7:0] ADDR_CFG_A = 8'h00;
   localparam logic [7:0] ADDR_CFG_B = 8'h04;
   localparam logic [7:0] ADDR_CFG_C = 8'h08;
   localparam logic [7:0] ADDR_CFG_D = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_DOT_CTRL = 8'h14;
   // Strap pin count and field positions
   localparam int STRAP_W = 29;
   localparam int BUS_LSB = 0;
   localparam int PAGE_LSB = 2;
   localparam int ROM_EN_BIT = 4;
   localparam int MEM_LSB = 5;
   localparam int CHIP_EN_BIT = 8;
   localparam int CLK_SEL_BIT = 11;
   localparam int SNOOP_BIT = 12;
   localparam int B_CLK_SEL_BIT = 3;
   localparam int B_SNOOP_BIT = 4;
   // Field encodings
   localparam logic [1:0] BUS_VL = 2'h1;
   localparam logic [1:0] BUS_PCI = 2'h2;
   localparam logic [1:0] PAGE_EDO1 = 2'h0;
   localparam logic [1:0] PAGE_RSVD = 2'h1;
   localparam logic [1:0] PAGE_EDO2 = 2'h2;
   localparam logic [1:0] PAGE_FAST = 2'h3;
   localparam logic [2:0] MEM_4M = 3'h0;
   localparam logic [2:0] MEM_2M = 3'h4;
   localparam logic [2:0] MEM_1M = 3'h6;
   // Power-on defaults: every strap reads one until captured
   localparam logic [7:0] CFG_RESET = 8'hFF;
   // Dot clock threshold above which the pixel path doubles
   localparam int DOUBLE_MHZ = 80;
   // Reset pulse width
   localparam int RESET_MIN_NS = 400;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {POSC_IN_RESET, POSC_CAPTURE, POSC_RUN} posc_state_t;
endpackage : posc_pkg

// ### posc_cfg_if.sv
`timescale 1ns/10ps
interface posc_cfg_if;
   logic [7:0] cfg_a;
   logic [7:0] cfg_b;
   logic [7:0] cfg_c;
   logic [7:0] cfg_d;
   logic [7:0] dot_mhz;
   logic bus_pci;
   logic bus_vl;
   logic bus_bad;
   logic page_bad;
   logic mem_bad;
   logic chip_en;
   logic rom_en;
   logic clk_int;
   logic snoop_en;
   logic dot_double;
   modport src (output cfg_a, cfg_b, cfg_c, cfg_d, dot_mhz);
   modport dec (input cfg_a, cfg_b, cfg_c, cfg_d, dot_mhz,
      output bus_pci, bus_vl, bus_bad, page_bad, mem_bad, chip_en, rom_en, clk_int, snoop_en, dot_double);
endinterface : posc_cfg_if

// ### posc_strap_sync.sv
`timescale 1ns/10ps
module posc_strap_sync (
   input wire logic pclk,
   input wire logic [posc_pkg::STRAP_W-1:0] pins,
   output logic [posc_pkg::STRAP_W-1:0] value,
   output logic stable
);
   typedef struct packed {
      logic [posc_pkg::STRAP_W-1:0] s1;
      logic [posc_pkg::STRAP_W-1:0] s2;
      logic [posc_pkg::STRAP_W-1:0] s3;
   } posc_sync_t;
   posc_sync_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.s1 = pins;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end
   // No reset: the stages keep sampling through reset, so the strap levels are settled when it lifts
   always_ff @(posedge pclk) begin
      st_q <= st_d;
   end
   // Only stages two and three are compared; stage one feeds stage two alone
   assign value = st_q.s2;
   assign stable = (st_q.s2 == st_q.s3);
endmodule : posc_strap_sync

// ### posc_decode.sv
`timescale 1ns/10ps
module posc_decode (
   posc_cfg_if.dec cfg
);
   function automatic logic mem_legal(input logic [2:0] m);
      mem_legal = (m == posc_pkg::MEM_4M) || (m == posc_pkg::MEM_2M) || (m == posc_pkg::MEM_1M);
   endfunction : mem_legal
   logic [1:0] bus_f;
   assign bus_f = cfg.cfg_a[posc_pkg::BUS_LSB +: 2];
   assign cfg.bus_pci = (bus_f == posc_pkg::BUS_PCI);
   assign cfg.bus_vl = (bus_f == posc_pkg::BUS_VL);
   assign cfg.bus_bad = !(cfg.bus_pci || cfg.bus_vl);
   assign cfg.page_bad = (cfg.cfg_a[posc_pkg::PAGE_LSB +: 2] == posc_pkg::PAGE_RSVD);
   assign cfg.mem_bad = !mem_legal(cfg.cfg_a[posc_pkg::MEM_LSB +: 3]);
   // Chip enable and ROM gating only apply on VL-Bus; PCI is always fully enabled
   assign cfg.chip_en = !cfg.bus_vl || cfg.cfg_b[0];
   assign cfg.rom_en = !cfg.bus_vl || cfg.cfg_a[posc_pkg::ROM_EN_BIT];
   assign cfg.clk_int = cfg.cfg_b[posc_pkg::B_CLK_SEL_BIT];
   assign cfg.snoop_en = cfg.bus_vl && cfg.cfg_b[posc_pkg::B_SNOOP_BIT];
   assign cfg.dot_double = (cfg.dot_mhz > 8'(posc_pkg::DOUBLE_MHZ));
endmodule : posc_decode

// ### posc_board_model.sv
`timescale 1ns/10ps
module posc_board_model (
   input wire logic pclk,
   input wire logic rst_req,
   input wire logic [posc_pkg::STRAP_W-1:0] pull_down,
   input wire logic [posc_pkg::STRAP_W-1:0] oe_n,
   input wire logic [posc_pkg::STRAP_W-1:0] drv,
   input wire logic [posc_pkg::STRAP_W-1:0] pull_up,
   output logic presetn,
   output logic [posc_pkg::STRAP_W-1:0] pins
);
   logic [2:0] low_cnt_q = 3'h0;
   logic [posc_pkg::STRAP_W-1:0] last_q = '1;
   initial begin
      presetn = 1'b0;
   end
   // Low for at least five cycles, a margin over the 400 ns minimum
   always @(posedge pclk) begin
      if (rst_req) begin
         presetn <= 1'b0;
         low_cnt_q <= 3'h0;
      end else if (low_cnt_q < 3'h5) begin
         low_cnt_q <= low_cnt_q + 3'h1;
      end else begin
         presetn <= 1'b1;
      end
   end
   always @(posedge pclk) begin
      last_q <= pins;
   end
   // A pin with no pull at all floats; it shows the inverse of its last level
   always_comb begin
      pins = (~oe_n & drv) | (oe_n & ~pull_down & (pull_up | ~last_q));
   end
endmodule : posc_board_model

// ### power_on_strap_capture_tb_top.sv
`timescale 1ns/10ps
module power_on_strap_capture_tb_top;
   localparam int W = posc_pkg::STRAP_W;
   logic pclk = 1'b0;
   logic rst_req = 1'b1;
   logic presetn;
   logic [W-1:0] pins;
   logic [W-1:0] pull_down = '0;
   logic [W-1:0] pix_out = '0;
   logic [W-1:0] pix_drive = '0;
   logic [W-1:0] pins_out, oe_n, pull_up;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd_q;
   logic pready, pslverr, err_q;
   logic pci, vl, chip, rom, clk_int, snoop, dbl;
   logic [1:0] page;
   logic [2:0] mem;
   int n_fail = 0;
   int checked = 0;
   logic [28:0] straps [4] = '{29'h15A3199D, 29'h0C5A1002, 29'h1F0E08C9, 29'h00000916};

   always #50 pclk = ~pclk;

   posc_board_model u_board (.pclk(pclk), .rst_req(rst_req), .pull_down(pull_down), .oe_n(oe_n),
      .drv(pins_out), .pull_up(pull_up), .presetn(presetn), .pins(pins));

   posc_strap_capture u_dut (.pclk(pclk), .presetn(presetn), .strap_pixel_pins_in(pins),
      .pix_data_out(pix_out), .pix_data_drive(pix_drive), .strap_pixel_pins_out(pins_out),
      .strap_pixel_pins_oe_n(oe_n), .strap_pixel_pins_pull_up(pull_up), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_pci_en(pci), .bus_vl_en(vl), .chip_enable(chip),
      .rom_enable(rom), .clk_internal(clk_int), .ramdac_snoop_en(snoop), .dot_double_en(dbl),
      .page_mode(page), .mem_size(mem));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Ends with an idle cycle so a following setup never lands in the release time step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic do_capture(input logic [28:0] s);
      pull_down <= ~s;
      pix_drive <= '1;
      rst_req <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(pull_up, 32'h1FFFFFFF);
      chk(oe_n, 32'h1FFFFFFF);
      chk({pready, pci, vl}, 32'h0);
      rst_req <= 1'b0;
      pix_drive <= '0;
      @(posedge pclk);
      while (presetn !== 1'b1) begin
         @(posedge pclk);
      end
      rd_q = 32'h0;
      while (rd_q[5] !== 1'b1) begin
         apb(1'b0, posc_pkg::ADDR_STATUS, 32'h0);
      end
      @(posedge pclk);
   endtask : do_capture

   task automatic case_chk(input logic [28:0] s);
      logic is_vl;
      is_vl = (s[1:0] == 2'h1);
      do_capture(s);
      apb(1'b0, posc_pkg::ADDR_CFG_A, 32'h0);
      chk(rd_q, {24'h0, s[7:0]});
      apb(1'b0, posc_pkg::ADDR_CFG_B, 32'h0);
      chk(rd_q, {24'h0, s[15:8]});
      apb(1'b0, posc_pkg::ADDR_CFG_C, 32'h0);
      chk(rd_q, {24'h0, s[23:16]});
      apb(1'b0, posc_pkg::ADDR_CFG_D, 32'h0);
      chk(rd_q, {27'h0, s[28:24]});
      chk({pci, vl}, {s[1:0] == 2'h2, is_vl});
      chk(page, s[3:2]);
      chk(rom, is_vl ? s[4] : 1'b1);
      chk(mem, s[7:5]);
      chk(chip, is_vl ? s[8] : 1'b1);
      chk(clk_int, s[11]);
      chk(snoop, is_vl & s[12]);
      pull_down <= s;
      repeat (6) @(posedge pclk);
      apb(1'b0, posc_pkg::ADDR_CFG_A, 32'h0);
      chk(rd_q, {24'h0, s[7:0]});
      chk(page, s[3:2]);
      pix_drive <= '1;
      pix_out <= ~s;
      repeat (3) @(posedge pclk);
      chk(oe_n, 32'h0);
      chk(pull_up, 32'h0);
      chk(pins, {3'h0, ~s});
      pix_drive <= '0;
      @(posedge pclk);
   endtask : case_chk

   task automatic reg_scn();
      do_capture(straps[0]);
      apb(1'b1, posc_pkg::ADDR_CFG_A, 32'h000000C2);
      apb(1'b0, posc_pkg::ADDR_CFG_A, 32'h0);
      chk(rd_q, 32'h000000DD);
      chk(mem, posc_pkg::MEM_1M);
      apb(1'b1, posc_pkg::ADDR_CFG_B, 32'h0);
      apb(1'b0, posc_pkg::ADDR_CFG_B, 32'h0);
      chk(rd_q, 32'h00000019);
      apb(1'b1, 8'h18, 32'hFF);
      chk(err_q, 1'b1);
      apb(1'b0, 8'h18, 32'h0);
      chk({err_q, rd_q}, {1'b1, 32'h0});
      apb(1'b1, posc_pkg::ADDR_DOT_CTRL, 32'd80);
      @(posedge pclk);
      chk(dbl, 1'b0);
      apb(1'b1, posc_pkg::ADDR_DOT_CTRL, 32'd81);
      @(posedge pclk);
      chk(dbl, 1'b1);
   endtask : reg_scn

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (10) @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
         case_chk(straps[i]);
      end
      reg_scn();
      close_out();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      close_out();
   end
endmodule : power_on_strap_capture_tb_top
